// >>> hw/dsw_top.sv
// pin control, serial port and status logic of the dual high-side switch
//
// Chosen here: the register offsets and the Wishbone slave port.
`timescale 1ns/1ns
module dsw_top
    import dsw_pkg::*;
#(
    parameter int FS_CYCLES = FS_TIMEOUT_CYC
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST,
    // wishbone slave
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    output logic IRQ_O,
    // device pins
    input wire logic DEVICE_RESET_N,
    input wire logic DIRECT_CTRL_CH0,
    input wire logic DIRECT_CTRL_CH1,
    input wire logic PROFILE_SEL_CH0,
    input wire logic PROFILE_SEL_CH1,
    input wire logic PWM_CLK_IN,
    // serial port pins
    input wire logic SERIAL_SELECT_N,
    input wire logic SCLK,
    input wire logic SI,
    output logic SO,
    output logic SO_OE,
    // analog side
    input wire logic OVERCUR_CH0,
    input wire logic OVERCUR_CH1,
    input wire logic SENSE_IN_RANGE,
    output logic SENSE_SRC_TEMP,
    output logic SENSE_RATIO_HI,
    output logic SENSE_CH_SEL,
    output logic SWITCH_OUT_CH0,
    output logic SWITCH_OUT_CH1,
    // open-drain status flags
    output logic FAILSAFE_FLAG_N_O,
    output logic FAILSAFE_FLAG_N_OE,
    output logic FAULT_FLAG_N_O,
    output logic FAULT_FLAG_N_OE,
    output logic SENSE_VALID_N_O,
    output logic SENSE_VALID_N_OE
);

    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [10:0] pins_s;
    logic dev_rst_n_s, cs_n_s, sclk_s, si_s, pwmclk_s, range_s;
    logic sense_range_meta_q, sense_range_q;
    // reset and select pins idle high: flipped so a cleared synchroniser reads idle
    localparam logic [10:0] PINS_IDLE_HI = 11'h410;
    logic [1:0] direct_s, profile_s, oc_s;

    dsw_sync #(.W(11)) u_sync (
        .clk(CLK),
        .rst(RST),
        .d(PINS_IDLE_HI ^ {DEVICE_RESET_N, DIRECT_CTRL_CH1, DIRECT_CTRL_CH0, PROFILE_SEL_CH1,
            PROFILE_SEL_CH0, PWM_CLK_IN, SERIAL_SELECT_N, SCLK, SI, OVERCUR_CH1, OVERCUR_CH0}),
        .q(pins_s)
    );
    assign {dev_rst_n_s, direct_s, profile_s, pwmclk_s, cs_n_s, sclk_s, si_s, oc_s} =
        pins_s ^ PINS_IDLE_HI;
    assign range_s = sense_range_q;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sense_range_meta_q <= 1'b0;
            sense_range_q <= 1'b0;
        end else begin
            sense_range_meta_q <= SENSE_IN_RANGE;
            sense_range_q <= sense_range_meta_q;
        end
    end

    // byte-lane merge of a bus write into a narrow register
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = wd[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ************************************************************
    // bus decode
    // ************************************************************
    logic ack_q, req, wr;
    logic [CTRL_W-1:0] ctrl_q;
    logic [IRQ_W-1:0] irq_stat_q, irq_mask_q, irq_ev;
    logic [SPI_W-1:0] tx_q, rx_q;
    logic [7:0] duty_q;
    logic [FAULT_W-1:0] fault_q;
    logic [STAT_W-1:0] status;
    logic [31:0] rdata;
    dsw_mode_e mode_q;
    logic [1:0] sw_q, profile_eff;
    logic sense_valid_q;

    assign req = CYC_I & STB_I & ~ack_q;
    assign wr = req & WE_I;
    assign status = {sense_valid_q, mode_q == MODE_SLEEP, |fault_q, mode_q == MODE_FAILSAFE,
                     profile_eff, sw_q};

    always_comb begin
        rdata = 32'h0000_0000;
        unique case (ADR_I)
            ADDR_CTRL: rdata[CTRL_W-1:0] = ctrl_q;
            ADDR_STATUS: rdata[STAT_W-1:0] = status;
            ADDR_IRQ_STAT: rdata[IRQ_W-1:0] = irq_stat_q;
            ADDR_IRQ_MASK: rdata[IRQ_W-1:0] = irq_mask_q;
            ADDR_SPI_TX: rdata[SPI_W-1:0] = tx_q;
            ADDR_SPI_RX: rdata[SPI_W-1:0] = rx_q;
            ADDR_PWM: rdata[7:0] = duty_q;
            ADDR_FAULT: rdata[FAULT_W-1:0] = fault_q;
            default: rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ack_q <= 1'b0;
            DAT_O <= 32'h0000_0000;
        end else begin
            ack_q <= req;
            DAT_O <= req ? rdata : 32'h0000_0000;
        end
    end
    assign ACK_O = ack_q;

    // ************************************************************
    // configuration registers
    // ************************************************************
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ctrl_q <= CTRL_RST;
            irq_mask_q <= IRQ_MASK_RST;
            tx_q <= SPI_RST;
            duty_q <= DUTY_RST;
        end else if (!dev_rst_n_s) begin
            ctrl_q <= CTRL_RST;
            irq_mask_q <= IRQ_MASK_RST;
            tx_q <= SPI_RST;
            duty_q <= DUTY_RST;
        end else if (wr) begin
            if (ADR_I == ADDR_CTRL) ctrl_q <= CTRL_W'(lane_merge(32'(ctrl_q), DAT_I, SEL_I));
            if (ADR_I == ADDR_IRQ_MASK) irq_mask_q <= IRQ_W'(lane_merge(32'(irq_mask_q), DAT_I, SEL_I));
            if (ADR_I == ADDR_SPI_TX) tx_q <= SPI_W'(lane_merge(32'(tx_q), DAT_I, SEL_I));
            if (ADR_I == ADDR_PWM) duty_q <= 8'(lane_merge(32'(duty_q), DAT_I, SEL_I));
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            SENSE_SRC_TEMP <= 1'b0;
            SENSE_RATIO_HI <= 1'b0;
            SENSE_CH_SEL <= 1'b0;
        end else begin
            SENSE_SRC_TEMP <= ctrl_q[CTRL_SENSE_TEMP];
            SENSE_RATIO_HI <= ctrl_q[CTRL_RATIO_HI];
            SENSE_CH_SEL <= ctrl_q[CTRL_SENSE_CH];
        end
    end

    // ************************************************************
    // serial port
    // ************************************************************
    logic sclk_prev_q, cs_prev_q, frame_ev;
    logic [SPI_W-1:0] shift_q;
    logic [7:0] bitcnt_q;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sclk_prev_q <= 1'b0;
            cs_prev_q <= 1'b1;
            shift_q <= SPI_RST;
            bitcnt_q <= 8'h00;
            rx_q <= SPI_RST;
            SO <= 1'b0;
            SO_OE <= 1'b0;
        end else begin
            sclk_prev_q <= sclk_s;
            cs_prev_q <= cs_n_s;
            SO_OE <= ~cs_n_s;
            if (!cs_n_s && cs_prev_q) begin
                shift_q <= tx_q;
                SO <= tx_q[SPI_W-1];
                bitcnt_q <= 8'h00;
            end else if (!cs_n_s && sclk_s && !sclk_prev_q) begin
                shift_q <= {shift_q[SPI_W-2:0], si_s};
                if (bitcnt_q != 8'hFF) bitcnt_q <= bitcnt_q + 8'h01;
            end else if (!cs_n_s && !sclk_s && sclk_prev_q) begin
                SO <= shift_q[SPI_W-1];
            end
            if (frame_ev) rx_q <= shift_q;
        end
    end
    // a frame is whole when a multiple of sixteen bits, 16 to 240, was shifted
    assign frame_ev = cs_n_s & ~cs_prev_q & (bitcnt_q[3:0] == 4'h0) & (bitcnt_q != 8'h00);

    // ************************************************************
    // pwm time base
    // ************************************************************
    logic pwmclk_prev_q, tick;
    logic [7:0] div_q, pwm_cnt_q;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            pwmclk_prev_q <= 1'b0;
            div_q <= 8'h00;
            pwm_cnt_q <= 8'h00;
        end else begin
            pwmclk_prev_q <= pwmclk_s;
            div_q <= (div_q == 8'(PWM_TICK_CYC - 1)) ? 8'h00 : div_q + 8'h01;
            if (tick) pwm_cnt_q <= pwm_cnt_q + 8'h01;
        end
    end
    assign tick = ctrl_q[CTRL_PWM_EXT] ? (pwmclk_s & ~pwmclk_prev_q)
                                       : (div_q == 8'(PWM_TICK_CYC - 1));

    // ************************************************************
    // operating mode and watchdog
    // ************************************************************
    logic [31:0] wdog_q;
    logic fs_enter;

    assign fs_enter = (mode_q == MODE_NORMAL) && (wdog_q == 32'(FS_CYCLES - 1));

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            mode_q <= MODE_SLEEP;
            wdog_q <= 32'h0000_0000;
        end else begin
            wdog_q <= (frame_ev || mode_q != MODE_NORMAL) ? 32'h0000_0000 : wdog_q + 32'h1;
            if (!dev_rst_n_s) begin
                mode_q <= (|direct_s) ? MODE_NORMAL : MODE_SLEEP;
            end else begin
                unique case (mode_q)
                    MODE_NORMAL: if (fs_enter) mode_q <= MODE_FAILSAFE;
                    MODE_SLEEP: if (frame_ev || |direct_s) mode_q <= MODE_NORMAL;
                    MODE_FAILSAFE: if (frame_ev) mode_q <= MODE_NORMAL;
                    default: mode_q <= MODE_SLEEP;
                endcase
            end
        end
    end

    // ************************************************************
    // channels, overcurrent profile and faults
    // ************************************************************
    logic [1:0] ch_req, ch_on, pwm_en, clr_fault, trip;
    logic [9:0] blank_q [2];

    assign profile_eff = profile_s ^ {2{ctrl_q[CTRL_PROFILE_INV]}};
    assign pwm_en = {ctrl_q[CTRL_PWM_EN1], ctrl_q[CTRL_PWM_EN0]};
    assign clr_fault = (wr && ADR_I == ADDR_FAULT && SEL_I[0]) ? DAT_I[1:0] : 2'b00;

    always_comb begin
        for (int i = 0; i < 2; i++) begin
            ch_req[i] = direct_s[i]
                      | (mode_q == MODE_NORMAL && pwm_en[i] && pwm_cnt_q < duty_q);
            ch_on[i] = ch_req[i] & ~fault_q[i] & (mode_q != MODE_SLEEP);
            trip[i] = sw_q[i] & oc_s[i] & (blank_q[i] == 10'h000);
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            sw_q <= 2'b00;
            fault_q <= 2'b00;
            blank_q[0] <= 10'h000;
            blank_q[1] <= 10'h000;
        end else begin
            sw_q <= ch_on;
            for (int i = 0; i < 2; i++) begin
                if (ch_on[i] && !sw_q[i]) begin
                    // motor profile blanks inrush far shorter than bulb
                    blank_q[i] <= profile_eff[i] ? 10'(MOTOR_BLANK_CYC) : 10'(BULB_BLANK_CYC);
                end else if (blank_q[i] != 10'h000) begin
                    blank_q[i] <= blank_q[i] - 10'h001;
                end
                if (!dev_rst_n_s) fault_q[i] <= 1'b0;
                else if (trip[i]) fault_q[i] <= 1'b1;
                else if (clr_fault[i]) fault_q[i] <= 1'b0;
            end
        end
    end
    assign SWITCH_OUT_CH0 = sw_q[0];
    assign SWITCH_OUT_CH1 = sw_q[1];

    // ************************************************************
    // sense validity and status flags
    // ************************************************************
    logic [7:0] settle_q;
    logic [2:0] sense_cfg_q;
    logic fault_oe_q, fs_oe_q;

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            settle_q <= 8'(SENSE_SETTLE_CYC);
            sense_cfg_q <= 3'h0;
            sense_valid_q <= 1'b0;
            fault_oe_q <= 1'b0;
            fs_oe_q <= 1'b0;
        end else begin
            sense_cfg_q <= {sw_q != ch_on, ctrl_q[CTRL_SENSE_CH], ctrl_q[CTRL_SENSE_TEMP]};
            if (sense_cfg_q != {sw_q != ch_on, ctrl_q[CTRL_SENSE_CH], ctrl_q[CTRL_SENSE_TEMP]}
                || sense_cfg_q[2]) begin
                settle_q <= 8'(SENSE_SETTLE_CYC);
            end else if (settle_q != 8'h00) begin
                settle_q <= settle_q - 8'h01;
            end
            sense_valid_q <= range_s && settle_q == 8'h00;
            fault_oe_q <= |fault_q;
            fs_oe_q <= mode_q == MODE_FAILSAFE;
        end
    end
    assign SENSE_VALID_N_O = 1'b0;
    assign SENSE_VALID_N_OE = sense_valid_q;
    assign FAULT_FLAG_N_O = 1'b0;
    assign FAULT_FLAG_N_OE = fault_oe_q;
    assign FAILSAFE_FLAG_N_O = 1'b0;
    assign FAILSAFE_FLAG_N_OE = fs_oe_q;

    // ************************************************************
    // interrupts
    // ************************************************************
    logic irq_q, rd_clr;

    assign irq_ev = {frame_ev, fs_enter, trip[1] & ~fault_q[1], trip[0] & ~fault_q[0]};
    assign rd_clr = req & ~WE_I & (ADR_I == ADDR_IRQ_STAT);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            irq_stat_q <= 4'h0;
            irq_q <= 1'b0;
        end else begin
            irq_stat_q <= (rd_clr ? 4'h0 : irq_stat_q) | irq_ev;
            irq_q <= |(irq_stat_q & irq_mask_q);
        end
    end
    assign IRQ_O = irq_q;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_direct_switch_on: assert property ((direct_s[0] && !fault_q[0] && mode_q != MODE_SLEEP)
        |=> sw_q[0]) else $error("direct input did not switch channel 0 on");
    a_failsafe_flag: assert property ((mode_q == MODE_FAILSAFE) |=> FAILSAFE_FLAG_N_OE)
        else $error("fail-safe flag not driven in fail-safe mode");
    a_fault_flag: assert property ($rose(|fault_q) |=> FAULT_FLAG_N_OE)
        else $error("fault flag not driven after fault latch");
    a_profile_blank: assert property ((ch_on[0] && !sw_q[0] && profile_eff[0])
        |=> blank_q[0] == 10'(MOTOR_BLANK_CYC)) else $error("motor blanking not loaded");
    a_profile_invert: assert property ((ch_on[0] && !sw_q[0]
        && !(profile_s[0] ^ ctrl_q[CTRL_PROFILE_INV])) |=> blank_q[0] == 10'(BULB_BLANK_CYC))
        else $error("profile not taken from pin and invert bit");
    a_reset_clears_cfg: assert property (!dev_rst_n_s |=> ctrl_q == CTRL_RST && fault_q == 2'b00)
        else $error("reset pin did not clear configuration");
    a_reset_sleep: assert property ((!dev_rst_n_s && direct_s == 2'b00) |=> mode_q == MODE_SLEEP)
        else $error("reset pin did not enter sleep");
    a_ext_tick: assert property ((ctrl_q[CTRL_PWM_EXT] && $rose(pwmclk_s))
        |=> pwm_cnt_q == $past(pwm_cnt_q) + 8'h01) else $error("external clock edge lost");
    a_shift_in: assert property ((!cs_n_s && !cs_prev_q && $rose(sclk_s))
        |=> shift_q[0] == $past(si_s)) else $error("serial input bit not captured");
    a_shift_out: assert property ((!cs_n_s && !cs_prev_q && $fell(sclk_s))
        |=> SO == $past(shift_q[SPI_W-1])) else $error("serial output bit wrong");
    a_sense_valid: assert property (SENSE_VALID_N_OE |-> $past(settle_q) == 8'h00 && $past(range_s))
        else $error("sense valid while not settled");
    a_sense_config: assert property ($changed(ctrl_q[CTRL_SENSE_TEMP]) |=> ##1
        SENSE_SRC_TEMP == $past(ctrl_q[CTRL_SENSE_TEMP], 2)) else $error("sense source wrong");
    a_bus_ack: assert property (req |=> ack_q ##1 !ack_q) else $error("ack not one cycle");

    c_frame: cover property (frame_ev);
    c_failsafe: cover property (mode_q == MODE_FAILSAFE ##[1:20] frame_ev);
    c_fault: cover property ($rose(fault_q[0]));
    c_irq: cover property ($rose(IRQ_O));

endmodule // dsw_top

// >>> hw/dsw_pkg.sv
// constants, register map and types of the dual switch pin control block
package dsw_pkg;

    // ************************************************************
    // clock
    // ************************************************************
    localparam int CLK_PERIOD_NS = 20;

    // least time in ns to whole clock cycles, never below one
    function automatic int cyc_min(input int t_ns);
        int c;
        c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // ************************************************************
    // register byte addresses
    // ************************************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_SPI_TX = 8'h10;
    localparam logic [7:0] ADDR_SPI_RX = 8'h14;
    localparam logic [7:0] ADDR_PWM = 8'h18;
    localparam logic [7:0] ADDR_FAULT = 8'h1C;

    // ************************************************************
    // control register fields
    // ************************************************************
    localparam int CTRL_W = 7;
    localparam int CTRL_SENSE_TEMP = 0;
    localparam int CTRL_RATIO_HI = 1;
    localparam int CTRL_SENSE_CH = 2;
    localparam int CTRL_PWM_EN0 = 3;
    localparam int CTRL_PROFILE_INV = 4;
    localparam int CTRL_PWM_EN1 = 5;
    localparam int CTRL_PWM_EXT = 6;
    localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;

    // ************************************************************
    // status, interrupt and data fields
    // ************************************************************
    localparam int STAT_W = 8;
    localparam int IRQ_W = 4;
    localparam int IRQ_FAULT0 = 0;
    localparam int IRQ_FAULT1 = 1;
    localparam int IRQ_FAILSAFE = 2;
    localparam int IRQ_FRAME = 3;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;
    localparam int SPI_W = 16;
    localparam logic [SPI_W-1:0] SPI_RST = 16'h0000;
    localparam logic [7:0] DUTY_RST = 8'h80;
    localparam int FAULT_W = 2;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int PWM_TICK_NS = 1000;
    localparam int PWM_TICK_CYC = cyc_min(PWM_TICK_NS);
    localparam int BULB_BLANK_US = 20;
    localparam int BULB_BLANK_CYC = cyc_min(BULB_BLANK_US * 1000);
    localparam int MOTOR_BLANK_US = 2;
    localparam int MOTOR_BLANK_CYC = cyc_min(MOTOR_BLANK_US * 1000);
    localparam int SENSE_SETTLE_US = 4;
    localparam int SENSE_SETTLE_CYC = cyc_min(SENSE_SETTLE_US * 1000);
    localparam int FS_TIMEOUT_US = 256;
    localparam int FS_TIMEOUT_CYC = cyc_min(FS_TIMEOUT_US * 1000);

    // ************************************************************
    // operating modes
    // ************************************************************
    typedef enum logic [1:0] {
        MODE_NORMAL = 2'b00,
        MODE_SLEEP = 2'b01,
        MODE_FAILSAFE = 2'b10
    } dsw_mode_e;

endpackage

// >>> hw/dsw_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/1ns
module dsw_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // pins in and synchronised levels out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule // dsw_sync

// >>> verification/dsw_host_model.sv
// serial host model for the block's serial port, mode 0, msb first
`timescale 1ns/1ns
module dsw_host_model (
    // serial pins
    output logic sel_n,
    output logic sclk,
    output logic si,
    input wire logic so
);
    // select idles high, clock stands still low and data idles low between frames
    initial begin
        sel_n = 1'b1;
        sclk = 1'b0;
        si = 1'b0;
    end
    // n bits out on si, so collected at each rising clock
    task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
        rx = 32'h0;
        #13 sel_n = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            si = tx[i];
            #80 sclk = 1'b1;
            rx = {rx[30:0], so};
            #80 sclk = 1'b0;
        end
        #80 sel_n = 1'b1;
        si = 1'b0;
    endtask
endmodule // dsw_host_model

// >>> verification/dsw_top_tb.sv
// self-checking bench of the dual switch pin control block
`timescale 1ns/1ns
module dsw_top_tb
    import dsw_pkg::*;
;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic cyc = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic dev_rst_n = 1'b1;
    logic [1:0] dir = 2'h0;
    logic [1:0] prof = 2'h0;
    logic [1:0] oc = 2'h0;
    logic in_range = 1'b0;
    logic pwm_clk = 1'b0;
    logic [31:0] rd, rx, dat_o;
    logic sel_n, sclk, si, so, so_oe, so_line, ack, irq, temp, ratio, ch_sel;
    logic sw0, sw1, fs_oe, ft_oe, sv_oe, fs_o, ft_o, sv_o;
    logic [7:0] ra [4] = '{ADDR_CTRL, ADDR_IRQ_MASK, ADDR_PWM, 8'h20};
    logic [31:0] re [4] = '{32'h0, 32'h0, {24'h0, DUTY_RST}, 32'h0};
    int n_fail = 0;
    int tests_run = 0;
    always #10 clk = ~clk;
    always #80 pwm_clk = ~pwm_clk;
    // released serial output never shows a stale level
    assign so_line = so_oe ? so : ~so;
    dsw_top #(.FS_CYCLES(200)) DUT (
        .CLK(clk), .RST(rst), .CYC_I(cyc), .STB_I(cyc), .WE_I(we), .ADR_I(adr),
        .SEL_I(4'hF), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack), .IRQ_O(irq),
        .DEVICE_RESET_N(dev_rst_n), .DIRECT_CTRL_CH0(dir[0]), .DIRECT_CTRL_CH1(dir[1]),
        .PROFILE_SEL_CH0(prof[0]), .PROFILE_SEL_CH1(prof[1]), .PWM_CLK_IN(pwm_clk),
        .SERIAL_SELECT_N(sel_n), .SCLK(sclk), .SI(si), .SO(so), .SO_OE(so_oe),
        .OVERCUR_CH0(oc[0]), .OVERCUR_CH1(oc[1]), .SENSE_IN_RANGE(in_range),
        .SENSE_SRC_TEMP(temp), .SENSE_RATIO_HI(ratio), .SENSE_CH_SEL(ch_sel),
        .SWITCH_OUT_CH0(sw0), .SWITCH_OUT_CH1(sw1), .FAILSAFE_FLAG_N_O(fs_o),
        .FAILSAFE_FLAG_N_OE(fs_oe), .FAULT_FLAG_N_O(ft_o), .FAULT_FLAG_N_OE(ft_oe),
        .SENSE_VALID_N_O(sv_o), .SENSE_VALID_N_OE(sv_oe));
    dsw_host_model host (.sel_n(sel_n), .sclk(sclk), .si(si), .so(so_line));
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // classic cycle: hold until ack is seen, data taken at that edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] r);
        int k;
        k = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= wd;
        @(posedge clk);
        while (ack !== 1'b1 && k < 100) begin
            @(posedge clk);
            k++;
        end
        if (k >= 100) begin
            n_fail++;
            tally_and_finish();
        end
        r = dat_o;
        cyc <= 1'b0;
        @(posedge clk);
    endtask
    task automatic waitv(ref logic s, input logic v);
        int k;
        k = 0;
        while (s !== v && k < 3000) begin
            @(negedge clk);
            k++;
        end
        if (k >= 3000) begin
            n_fail++;
            tally_and_finish();
        end
        chk(s, v);
        @(posedge clk);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int i = 0; i < 3; i++) begin
            wb(1'b1, ADDR_CTRL, 32'h40 | (32'h1 << i), rd);
            chk({29'h0, ch_sel, ratio, temp}, 32'h1 << i);
        end
        prof <= 2'h1;
        wb(1'b1, ADDR_PWM, 32'h33, rd);
        wb(1'b1, ADDR_IRQ_MASK, 32'hF, rd);
        wb(1'b0, ADDR_STATUS, 32'h0, rd);
        chk(rd & 32'hC, 32'h4);
        wb(1'b1, ADDR_CTRL, 32'h10, rd);
        wb(1'b0, ADDR_STATUS, 32'h0, rd);
        chk(rd & 32'hC, 32'h8);
        dir <= 2'h1;
        waitv(sw0, 1'b1);
        chk(sw1, 1'b0);
        for (int j = 0; j < 2; j++) begin
            dev_rst_n <= 1'b0;
            repeat (4) @(posedge clk);
            dev_rst_n <= 1'b1;
            repeat (4) @(posedge clk);
            wb(1'b0, ADDR_STATUS, 32'h0, rd);
            chk(rd & 32'h4D, j == 0 ? 32'h05 : 32'h44);
            dir <= 2'h0;
        end
        foreach (ra[i]) begin
            wb(1'b0, ra[i], 32'h0, rd);
            chk(rd, re[i]);
        end
        $display("test pins and device reset done");
        wb(1'b1, ADDR_IRQ_MASK, 32'h8, rd);
        wb(1'b1, ADDR_SPI_TX, 32'hA5C3, rd);
        wb(1'b0, ADDR_IRQ_STAT, 32'h0, rd);
        host.xfer(32, 32'hBEEF5678, rx);
        chk(rx, 32'hA5C3BEEF);
        repeat (6) @(negedge clk);
        chk(irq, 1'b1);
        chk(fs_oe, 1'b0);
        chk(so_oe, 1'b0);
        @(posedge clk);
        wb(1'b0, ADDR_SPI_RX, 32'h0, rd);
        chk(rd, 32'h5678);
        wb(1'b0, ADDR_IRQ_STAT, 32'h0, rd);
        chk(rd & 32'h8, 32'h8);
        waitv(irq, 1'b0);
        waitv(fs_oe, 1'b1);
        host.xfer(12, 32'hFFF, rx);
        @(posedge clk);
        wb(1'b0, ADDR_SPI_RX, 32'h0, rd);
        chk(rd, 32'h5678);
        $display("test serial port done");
        dir <= 2'h1;
        oc <= 2'h1;
        waitv(ft_oe, 1'b1);
        oc <= 2'h0;
        wb(1'b1, ADDR_FAULT, 32'h1, rd);
        wb(1'b0, ADDR_FAULT, 32'h0, rd);
        chk(rd, 32'h0);
        waitv(ft_oe, 1'b0);
        in_range <= 1'b1;
        waitv(sv_oe, 1'b1);
        wb(1'b0, ADDR_STATUS, 32'h0, rd);
        chk(rd & 32'h80, 32'h80);
        in_range <= 1'b0;
        waitv(sv_oe, 1'b0);
        chk({29'h0, fs_o, ft_o, sv_o}, 32'h0);
        $display("test fault and sense flags done");
        tally_and_finish();
    end
endmodule // dsw_top_tb
